/* File: bench/mss_motor_model.sv */
`default_nettype none
module mss_motor_model (
   // Drive side
   input  wire logic        gateOn,
   input  wire logic [15:0] outFreq,
   input  wire logic [15:0] rotorFreq,
   // Feedback
   output logic [7:0]       current,
   output logic [15:0]      estFreq
);
   timeunit 1ns;
   timeprecision 1ns;
   // Slip above rotor speed draws high current; no drive, no current
   assign current = !gateOn ? 8'h00 : (outFreq > rotorFreq + 16'h0014) ? 8'hf0 : 8'h28;
   // Back-EMF reading of the coasting rotor
   assign estFreq = rotorFreq;
endmodule : mss_motor_model
`default_nettype wire

/* File: bench/mss_sequencer_properties.sv */
`default_nettype none
module mss_sequencer_properties
   import mss_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   // Clock and reset
   input wire logic         clk,
   input wire logic         nrst,
   // Watched ports
   input wire mss_pins_type pins,
   input wire logic [15:0]  outFreq_q,
   input wire logic [7:0]   outVolt_q,
   input wire logic         gateEnable_q,
   input wire logic         injectEnable_q,
   input wire logic         searchActive_q,
   input wire logic         searchDone_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Two cycles in a driven search, so the first loaded value is not judged
   sequence inSearch;
      searchActive_q && gateEnable_q && $past(searchActive_q && gateEnable_q);
   endsequence
   a_done_single: assert property (searchDone_q |=> !searchDone_q)
      else $error("done pulse longer than one cycle");
   a_done_cause: assert property (searchDone_q |-> $past(searchActive_q))
      else $error("done without a search");
   a_done_normal: assert property (searchDone_q |=> gateEnable_q && !searchActive_q)
      else $error("done without normal operation");
   a_inject_gate: assert property (injectEnable_q |-> searchActive_q && gateEnable_q)
      else $error("injection outside a driven search");
   a_run_stop: assert property ((!pins.run) [*5] |-> !searchActive_q && !gateEnable_q)
      else $error("search or output without run");
   a_freq_falls: assert property (inSearch |-> outFreq_q <= $past(outFreq_q))
      else $error("frequency rose during search");
   a_ramp_step: assert property (inSearch |-> $past(outFreq_q) - outFreq_q <= 16'h0001)
      else $error("ramp step too large");
   a_volt_rises: assert property (inSearch |-> outVolt_q >= $past(outVolt_q))
      else $error("voltage fell during search");
   c_done: cover property (searchDone_q);
   c_inject: cover property (injectEnable_q);
   c_gate: cover property ($rose(gateEnable_q) && searchActive_q);
endmodule : mss_sequencer_properties

bind mss_sequencer mss_sequencer_properties #(.TICK_CYC(TICK_CYC)) mss_sequencer_properties_inst (
   .clk(clk), .nrst(nrst), .pins(pins), .outFreq_q(outFreq_q), .outVolt_q(outVolt_q),
   .gateEnable_q(gateEnable_q), .injectEnable_q(injectEnable_q),
   .searchActive_q(searchActive_q), .searchDone_q(searchDone_q));
`default_nettype wire

/* File: bench/tb_motor_speed_search_sequencer.sv */
`default_nettype none
module tb_motor_speed_search_sequencer
   import mss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TC = 50;
   logic clk, nrst, read, write, faultRestart, waitrequest, sawInj;
   logic gateEnable_q, injectEnable_q, searchActive_q, searchDone_q;
   logic [5:0] address;
   logic [31:0] writedata, readdata, rv, seed;
   logic [15:0] outFreq_q, estimatedFreq, rotor;
   logic [7:0] outVolt_q, injectLevel_q, outputCurrent;
   mss_pins_type pins;
   int err_count, tests_run, gateCyc, mb, dl;
   logic [5:0] offs[7] = '{OFS_CTRL, OFS_THRESH, OFS_DELAY, OFS_MINBB, OFS_DECEL,
                           OFS_STATUS, 6'h30};
   logic [31:0] rsts[7] = '{0, 32'(THR_VF), 32'(DELAY_RST), 32'(MINBB_RST), 32'(DECEL_RST), 1, 0};

   mss_sequencer #(.TICK_CYC(TC)) mss_sequencer_inst (.clk(clk), .nrst(nrst), .clkEn(1'b1),
      .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .pins(pins), .faultRestart(faultRestart),
      .outputCurrent(outputCurrent), .estimatedFreq(estimatedFreq), .outFreq_q(outFreq_q),
      .outVolt_q(outVolt_q), .gateEnable_q(gateEnable_q), .injectEnable_q(injectEnable_q),
      .injectLevel_q(injectLevel_q), .searchActive_q(searchActive_q), .searchDone_q(searchDone_q));
   mss_motor_model mss_motor_model_inst (.gateOn(gateEnable_q), .outFreq(outFreq_q),
      .rotorFreq(rotor), .current(outputCurrent), .estFreq(estimatedFreq));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   // Free-running tick lets the wait start up to two ticks early
   function automatic int min_wait(int a, int b);
      return ((a > b) ? a - 2 : b - 2) * TC;
   endfunction : min_wait
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic wait_done();
      gateCyc = 0;
      sawInj = 0;
      while (gateEnable_q !== 1'b1 && gateCyc < 5000) begin
         @(posedge clk);
         gateCyc++;
      end
      repeat (20000) begin
         @(posedge clk);
         if (injectEnable_q === 1'b1) sawInj = 1;
         if (searchDone_q === 1'b1) break;
      end
   endtask : wait_done
   task automatic pulse_fault();
      faultRestart <= 1'b1;
      @(posedge clk);
      faultRestart <= 1'b0;
   endtask : pulse_fault
   task automatic search(logic [31:0] ctrl, logic expInj);
      mb = 2 + int'(xs() % 4);
      dl = 2 + int'(xs() % 4);
      rotor <= 16'd100 + 16'(xs() % 300);
      bus(1, OFS_CTRL, ctrl);
      bus(1, OFS_MINBB, mb);
      bus(1, OFS_DELAY, dl);
      pins.run <= 1'b1;
      wait_done();
      check(32'(gateCyc >= min_wait(mb, dl)), 1);
      check(sawInj, expInj);
      check(searchDone_q, 1);
      bus(0, OFS_STATUS, 0);
      check(rv[5:0], 6'h20);
      pins.run <= 1'b0;
      cyc(8);
   endtask : search

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      cyc(100000);
      err_count++;
      stop_test();
   end
   initial begin
      {nrst, read, write, faultRestart, address, writedata, pins} = '0;
      rotor = 16'd200;
      seed = 32'd78396;
      err_count = 0;
      tests_run = 0;
      cyc(5);
      nrst <= 1'b1;
      foreach (offs[i]) begin
         bus(0, offs[i], 0);
         check(rv, rsts[i]);
      end
      check(injectLevel_q, 32'(INJECT_RST));
      bus(1, OFS_CTRL, 32'h100);
      bus(0, OFS_THRESH, 0);
      check(rv, 32'h64);
      bus(1, OFS_THRESH, 32'h12c);
      bus(0, OFS_THRESH, 0);
      check(rv, 32'h1c8);
      bus(1, OFS_DELAY, 32'h7d0);
      bus(0, OFS_DELAY, 0);
      check(rv, 32'h3e8);
      bus(1, OFS_DECEL, 0);
      bus(0, OFS_DECEL, 0);
      check(rv, 32'h1);
      bus(1, OFS_DECEL, 32'h14);
      bus(1, OFS_THRESH, 32'h78);
      search(32'h002, 0);
      search(32'h003, 1);
      search(32'h282, 1);
      search(32'h005, 0);
      bus(1, OFS_CTRL, 0);
      pins.ext1 <= 1'b1;
      cyc(10);
      check(searchActive_q, 0);
      pins.ext1 <= 1'b0;
      pins.run <= 1'b1;
      cyc(10);
      check(searchActive_q, 0);
      pins.ext1 <= 1'b1;
      wait_done();
      check(searchDone_q, 1);
      pins.ext1 <= 1'b0;
      bus(1, OFS_CTRL, 1);
      pins.ext2 <= 1'b1;
      cyc(10);
      check(searchActive_q, 0);
      pulse_fault();
      cyc(10);
      check(searchActive_q, 0);
      bus(1, OFS_RESTART, 1);
      pulse_fault();
      wait_done();
      check(searchDone_q, 1);
      bus(1, OFS_CTRL, 0);
      pins.ext2 <= 1'b0;
      cyc(4);
      pins.ext2 <= 1'b1;
      wait_done();
      check(searchDone_q, 1);
      bus(1, OFS_CTRL, 32'h008);
      pins.powerLoss <= 1'b1;
      cyc(10);
      pins.powerLoss <= 1'b0;
      wait_done();
      check(32'(gateCyc >= min_wait(0, dl)), 1);
      check(searchDone_q, 1);
      pins.bbPin <= 1'b1;
      cyc(10);
      pins.bbPin <= 1'b0;
      wait_done();
      check(searchDone_q, 1);
      stop_test();
   end
endmodule : tb_motor_speed_search_sequencer
`default_nettype wire

/* File: rtl/mss_ramp.sv */
`default_nettype none
module mss_ramp (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   // Rate
   input  wire logic        enable,
   input  wire logic [15:0] span,
   input  wire logic [31:0] period,
   // Step strobe
   output logic             step
);
   logic [31:0] acc_q;
   logic [32:0] sum;

   // Span stays below period, so at most one step per cycle
   assign sum  = {1'b0, acc_q} + {17'h0, span};
   assign step = enable && (sum >= {1'b0, period});

   always_ff @(posedge clk) begin
      if (!nrst) begin
         acc_q <= '0;
      end else if (clkEn) begin
         if (!enable) begin
            acc_q <= '0;
         end else if (step) begin
            acc_q <= 32'(sum - {1'b0, period});
         end else begin
            acc_q <= sum[31:0];
         end
      end
   end
endmodule : mss_ramp
`default_nettype wire

/* File: rtl/mss_sequencer.sv */
`default_nettype none
module mss_sequencer
   import mss_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   // Avalon-MM slave
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Pins from outside
   input  wire mss_pins_type pins,
   // Drive-side feedback
   input  wire logic        faultRestart,
   input  wire logic [7:0]  outputCurrent,
   input  wire logic [15:0] estimatedFreq,
   // Power stage
   output logic [15:0]      outFreq_q,
   output logic [7:0]       outVolt_q,
   output logic             gateEnable_q,
   output logic             injectEnable_q,
   output logic [7:0]       injectLevel_q,
   output logic             searchActive_q,
   output logic             searchDone_q
);
   mss_cfg_type   cfg_q;
   mss_pins_type  pinS;
   mss_state_type state_q;
   logic          ack_q;
   logic          runPrev_q, bbPrev_q, pwrPrev_q, ext1Prev_q, ext2Prev_q;
   logic [31:0]   tickCnt_q;
   logic          tick;
   logic [15:0]   bbCnt_q, waitCnt_q;
   logic          modeRef_q, modeEst_q, short_q, needDelay_q;
   logic          methodEst, bbAct, blocked, thrLow, voltFull;
   logic [7:0]    thrEff;
   logic          fStep, vStep, fRampOn, vRampOn;
   logic          trig, trigRef, trigShort, trigDelay, goNorm;

   mss_sync u_sync (
      .clk     (clk),
      .nrst    (nrst),
      .clkEn   (clkEn),
      .pinsIn  (pins),
      .pinsOut (pinS)
   );

   function automatic logic [31:0] readMux(input logic [5:0] a, input mss_cfg_type c,
                                           input logic [7:0] t, input logic [5:0] s,
                                           input logic [15:0] f);
      case (a)
         OFS_CTRL:    readMux = {22'h0, c.ctrlMode, 1'b0, c.bbNc, c.rideThru,
                                 c.coastStop, c.atStart, c.method};
         OFS_THRESH:  readMux = {23'h0, c.thrSet, t};
         OFS_DELAY:   readMux = {22'h0, c.delay};
         OFS_MINBB:   readMux = {22'h0, c.minBb};
         OFS_DECEL:   readMux = {25'h0, c.decel};
         OFS_VREC:    readMux = {25'h0, c.vrec};
         OFS_INJECT:  readMux = {24'h0, c.inject};
         OFS_RESTART: readMux = {28'h0, c.restarts};
         OFS_FMAX:    readMux = {16'h0, c.fmax};
         OFS_FMIN:    readMux = {16'h0, c.fmin};
         OFS_FREF:    readMux = {16'h0, c.fref};
         OFS_STATUS:  readMux = {f, 10'h0, s};
         default:     readMux = 32'h0;
      endcase
   endfunction : readMux

   // One wait cycle per access; unmapped reads give zero, writes are dropped
   assign waitrequest = (read || write) && !ack_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ack_q    <= 1'b0;
         readdata <= 32'h0;
      end else if (clkEn) begin
         ack_q <= (read || write) && !ack_q;
         if (read && !ack_q) begin
            readdata <= readMux(address, cfg_q, thrEff, state_q, outFreq_q);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_q <= CFG_RST;
      end else if (clkEn && write && ack_q) begin
         case (address)
            OFS_CTRL: begin
               cfg_q.method    <= writedata[0];
               cfg_q.atStart   <= writedata[1];
               cfg_q.coastStop <= writedata[2];
               cfg_q.rideThru  <= writedata[4:3];
               cfg_q.bbNc      <= writedata[5];
               cfg_q.ctrlMode  <= writedata[9:7];
            end
            OFS_THRESH: begin
               // Clamp on the whole word, so large values do not wrap into range
               cfg_q.thr    <= (writedata > 32'(THR_MAX)) ? THR_MAX : writedata[7:0];
               cfg_q.thrSet <= 1'b1;
            end
            OFS_DELAY:   cfg_q.delay <= (writedata > 32'(DELAY_MAX)) ? DELAY_MAX
                                        : writedata[9:0];
            OFS_MINBB:   cfg_q.minBb <= writedata[9:0];
            OFS_DECEL:   cfg_q.decel <= (writedata < 32'(DECEL_MIN)) ? DECEL_MIN
                                      : (writedata > 32'(DECEL_MAX)) ? DECEL_MAX
                                      : writedata[6:0];
            OFS_VREC:    cfg_q.vrec <= (writedata[6:0] == 7'h0) ? 7'h01 : writedata[6:0];
            OFS_INJECT:  cfg_q.inject <= writedata[7:0];
            OFS_RESTART: cfg_q.restarts <= writedata[3:0];
            OFS_FMAX:    cfg_q.fmax <= writedata[15:0];
            OFS_FMIN:    cfg_q.fmin <= writedata[15:0];
            OFS_FREF:    cfg_q.fref <= writedata[15:0];
            default: ;
         endcase
      end
   end

   // Until software writes it, the threshold follows the control mode
   assign thrEff = cfg_q.thrSet ? cfg_q.thr
                 : (cfg_q.ctrlMode == CTRL_OLV) ? THR_OLV : THR_VF;
   // PM open loop vector has no current detection search
   assign methodEst = cfg_q.method || (cfg_q.ctrlMode == CTRL_PMOLV);
   assign bbAct     = cfg_q.bbNc ? !pinS.bbPin : pinS.bbPin;
   assign blocked   = bbAct || pinS.powerLoss;
   // Current only tells the speed once the output stage drives the motor
   assign thrLow    = gateEnable_q && (outputCurrent < thrEff);
   assign voltFull  = outVolt_q == VOLT_FULL;

   // Fixed timer tick for every wait
   assign tick = tickCnt_q == TICK_CYC - 1;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tickCnt_q <= '0;
      end else if (clkEn) begin
         tickCnt_q <= tick ? 32'h0 : tickCnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         runPrev_q  <= 1'b0;
         bbPrev_q   <= 1'b0;
         pwrPrev_q  <= 1'b0;
         ext1Prev_q <= 1'b0;
         ext2Prev_q <= 1'b0;
      end else if (clkEn) begin
         runPrev_q  <= pinS.run;
         bbPrev_q   <= bbAct;
         pwrPrev_q  <= pinS.powerLoss;
         ext1Prev_q <= pinS.ext1;
         ext2Prev_q <= pinS.ext2;
      end
   end

   // Launch decision, taken in STOP or NORM only
   always_comb begin
      trig      = 1'b0;
      trigRef   = 1'b0;
      trigShort = 1'b0;
      trigDelay = 1'b0;
      goNorm    = 1'b0;
      if (pinS.run && !blocked) begin
         if (state_q == ST_STOP) begin
            if (pwrPrev_q) begin
               trig      = (cfg_q.rideThru == 2'h1 || cfg_q.rideThru == 2'h2)
                           && cfg_q.restarts != 4'h0;
               trigShort = bbCnt_q < {6'h0, cfg_q.minBb};
               trigDelay = 1'b1;
            end else if (faultRestart) begin
               trig = cfg_q.restarts != 4'h0;
            end else if (bbPrev_q) begin
               trig      = outFreq_q > cfg_q.fmin;
               trigShort = 1'b1;
               goNorm    = !trig;
            end else if (!runPrev_q) begin
               trigDelay = 1'b1;
               if (cfg_q.coastStop && bbCnt_q < {6'h0, cfg_q.minBb}) begin
                  trig      = 1'b1;
                  trigShort = 1'b1;
               end else if (cfg_q.atStart) begin
                  trig = 1'b1;
               end else if (pinS.ext1) begin
                  trig = 1'b1;
               end else if (pinS.ext2 && !methodEst) begin
                  trig    = 1'b1;
                  trigRef = 1'b1;
               end else begin
                  goNorm = 1'b1;
               end
            end
         end else if (state_q == ST_NORM) begin
            if (faultRestart && cfg_q.restarts != 4'h0) begin
               trig = 1'b1;
            end else if (!cfg_q.atStart) begin
               trigDelay = 1'b1;
               if (pinS.ext1 && !ext1Prev_q) begin
                  trig = 1'b1;
               end else if (pinS.ext2 && !ext2Prev_q && !methodEst) begin
                  trig    = 1'b1;
                  trigRef = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ST_STOP;
      end else if (clkEn) begin
         if (!pinS.run || blocked) begin
            state_q <= ST_STOP;
         end else begin
            case (state_q)
               ST_STOP, ST_NORM: begin
                  if (trig) begin
                     state_q <= ST_WAIT;
                  end else if (goNorm) begin
                     state_q <= ST_NORM;
                  end
               end
               ST_WAIT: begin
                  // Both the min baseblock and, where due, the search delay must pass
                  if (bbCnt_q >= {6'h0, cfg_q.minBb} &&
                      (!needDelay_q || waitCnt_q >= {6'h0, cfg_q.delay})) begin
                     if (!modeEst_q) begin
                        state_q <= ST_CDET;
                     end else if (short_q) begin
                        state_q <= ST_EMF;
                     end else begin
                        state_q <= ST_INJ;
                     end
                  end
               end
               ST_EMF: begin
                  if (voltFull) begin
                     state_q <= ST_NORM;
                  end
               end
               ST_INJ, ST_CDET: begin
                  if (thrLow || outFreq_q <= cfg_q.fmin) begin
                     state_q <= ST_NORM;
                  end
               end
               default: state_q <= ST_STOP;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         modeEst_q   <= 1'b0;
         modeRef_q   <= 1'b0;
         short_q     <= 1'b0;
         needDelay_q <= 1'b0;
      end else if (clkEn && trig && state_q != ST_WAIT) begin
         modeEst_q   <= methodEst;
         modeRef_q   <= trigRef;
         short_q     <= trigShort;
         needDelay_q <= trigDelay;
      end
   end

   // Blocked time counts in STOP and WAIT; wait time counts in WAIT only
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bbCnt_q   <= '0;
         waitCnt_q <= '0;
      end else if (clkEn) begin
         if (state_q != ST_STOP && state_q != ST_WAIT) begin
            bbCnt_q <= '0;
         end else if (trig && trigDelay && !pwrPrev_q) begin
            bbCnt_q <= '0;
         end else if (tick && bbCnt_q != 16'hffff) begin
            bbCnt_q <= bbCnt_q + 16'h1;
         end
         if (state_q != ST_WAIT) begin
            waitCnt_q <= '0;
         end else if (tick && waitCnt_q != 16'hffff) begin
            waitCnt_q <= waitCnt_q + 16'h1;
         end
      end
   end

   assign fRampOn = state_q == ST_CDET || (state_q == ST_INJ && !thrLow)
                 || (state_q == ST_NORM && outFreq_q != cfg_q.fref);
   assign vRampOn = (state_q == ST_EMF || state_q == ST_INJ || state_q == ST_CDET) && !voltFull;

   mss_ramp u_freqRamp (
      .clk    (clk),
      .nrst   (nrst),
      .clkEn  (clkEn),
      .enable (fRampOn),
      .span   (cfg_q.fmax - cfg_q.fmin),
      .period (32'(cfg_q.decel) * TICK_CYC),
      .step   (fStep)
   );

   mss_ramp u_voltRamp (
      .clk    (clk),
      .nrst   (nrst),
      .clkEn  (clkEn),
      .enable (vRampOn),
      .span   ({8'h0, VOLT_FULL}),
      .period (32'(cfg_q.vrec) * TICK_CYC),
      .step   (vStep)
   );

   always_ff @(posedge clk) begin
      if (!nrst) begin
         outFreq_q <= '0;
         outVolt_q <= '0;
      end else if (clkEn) begin
         if (state_q == ST_WAIT) begin
            outVolt_q <= '0;
            if (!modeEst_q) begin
               outFreq_q <= modeRef_q ? cfg_q.fref : cfg_q.fmax;
            end else begin
               outFreq_q <= estimatedFreq;
            end
         end else begin
            if (vStep) begin
               outVolt_q <= outVolt_q + 8'h1;
            end
            if (state_q == ST_NORM) begin
               outVolt_q <= VOLT_FULL;
            end
            // Speed found: the reference is tracked from the detected value
            if (fStep && state_q == ST_NORM) begin
               outFreq_q <= (outFreq_q < cfg_q.fref) ? outFreq_q + 16'h1
                                                     : outFreq_q - 16'h1;
            end else if (fStep && outFreq_q > cfg_q.fmin) begin
               outFreq_q <= outFreq_q - 16'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         gateEnable_q   <= 1'b0;
         injectEnable_q <= 1'b0;
         injectLevel_q  <= '0;
         searchActive_q <= 1'b0;
         searchDone_q   <= 1'b0;
      end else if (clkEn) begin
         gateEnable_q   <= state_q != ST_STOP && state_q != ST_WAIT;
         injectEnable_q <= state_q == ST_INJ;
         injectLevel_q  <= cfg_q.inject;
         searchActive_q <= state_q != ST_STOP && state_q != ST_NORM;
         searchDone_q   <= pinS.run && !blocked && (((state_q == ST_INJ || state_q == ST_CDET)
                           && (thrLow || outFreq_q <= cfg_q.fmin))
                           || (state_q == ST_EMF && voltFull));
      end
   end
endmodule : mss_sequencer
`default_nettype wire

/* File: rtl/mss_sync.sv */
`default_nettype none
module mss_sync
   import mss_pkg::*;
(
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   nrst,
   input  wire logic   clkEn,
   // Pins
   input  wire mss_pins_type pinsIn,
   output mss_pins_type pinsOut
);
   mss_pins_type meta_q;

   // Only the second stage is visible outside
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_q  <= '0;
         pinsOut <= '0;
      end else if (clkEn) begin
         meta_q  <= pinsIn;
         pinsOut <= meta_q;
      end
   end
endmodule : mss_sync
`default_nettype wire

/* File: shared/mss_pkg.sv */
// What this block does
// - Method select 0 gives current detection (estimation under PM open loop vector), 1 gives estimation, for every source.
// - Short baseblock estimation: take back-EMF speed, recover voltage, then track reference.
// - Without back-EMF, estimation uses the current-injection variant.
// - Injection: output detected speed, raise voltage, lower frequency while current is high.
// - Current detection lowers frequency from max or reference until current falls.
// - After power returns, wait at least the search delay before searching.
// - Run or external search waits the longer of min baseblock and search delay.
// - Coast stop with run quickly reapplied searches as after a short baseblock.
// - Search at start enabled: search on every run, ignore external search inputs.
// - Search input 1 starts detection from max frequency, or estimation search.
// - Search input 2 starts detection from reference only under method 0, start off.
// - Search after fault restart needs a restart count above zero.
// - Power-loss search needs ride-through 1 or 2 and restart count above zero.
// - Baseblock release with run and frequency above minimum resumes with a search.
// - Deactivation threshold 0 to 200 percent, default 120 V/f, 100 open loop vector.
// - Current detection is not offered with permanent-magnet open loop vector.
// - Search ramp-down takes the decel time from max to min frequency, 0.1-10.0 s.
// - Search delay settable 0.0 to 100.0 s, default 0.2 s.
`default_nettype none
package mss_pkg;
   localparam int CLK_NS        = 40;
   localparam int TICK_NS       = 100_000_000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_NS;
   localparam logic [5:0] OFS_CTRL    = 6'h00;
   localparam logic [5:0] OFS_THRESH  = 6'h04;
   localparam logic [5:0] OFS_DELAY   = 6'h08;
   localparam logic [5:0] OFS_MINBB   = 6'h0c;
   localparam logic [5:0] OFS_DECEL   = 6'h10;
   localparam logic [5:0] OFS_VREC    = 6'h14;
   localparam logic [5:0] OFS_INJECT  = 6'h18;
   localparam logic [5:0] OFS_RESTART = 6'h1c;
   localparam logic [5:0] OFS_FMAX    = 6'h20;
   localparam logic [5:0] OFS_FMIN    = 6'h24;
   localparam logic [5:0] OFS_FREF    = 6'h28;
   localparam logic [5:0] OFS_STATUS  = 6'h2c;
   localparam logic [2:0] CTRL_VF     = 3'h0;
   localparam logic [2:0] CTRL_OLV    = 3'h2;
   localparam logic [2:0] CTRL_PMOLV  = 3'h5;
   localparam logic [7:0] THR_MAX     = 8'hc8;
   localparam logic [7:0] THR_VF      = 8'h78;
   localparam logic [7:0] THR_OLV     = 8'h64;
   localparam logic [9:0] DELAY_MAX   = 10'h3e8;
   localparam logic [9:0] DELAY_RST   = 10'h002;
   localparam logic [9:0] MINBB_RST   = 10'h005;
   localparam logic [6:0] DECEL_MIN   = 7'h01;
   localparam logic [6:0] DECEL_MAX   = 7'h64;
   localparam logic [6:0] DECEL_RST   = 7'h14;
   localparam logic [6:0] VREC_RST    = 7'h03;
   localparam logic [7:0] INJECT_RST  = 8'h32;
   localparam logic [15:0] FMAX_RST   = 16'h0258;
   localparam logic [15:0] FMIN_RST   = 16'h000f;
   localparam logic [7:0] VOLT_FULL   = 8'hff;

   typedef enum logic [5:0] {
      ST_STOP = 6'h01,
      ST_WAIT = 6'h02,
      ST_EMF  = 6'h04,
      ST_INJ  = 6'h08,
      ST_CDET = 6'h10,
      ST_NORM = 6'h20
   } mss_state_type;

   typedef struct packed {
      logic        run;
      logic        ext1;
      logic        ext2;
      logic        bbPin;
      logic        powerLoss;
   } mss_pins_type;

   typedef struct packed {
      logic        method;
      logic        atStart;
      logic        coastStop;
      logic [1:0]  rideThru;
      logic        bbNc;
      logic [2:0]  ctrlMode;
      logic [7:0]  thr;
      logic        thrSet;
      logic [9:0]  delay;
      logic [9:0]  minBb;
      logic [6:0]  decel;
      logic [6:0]  vrec;
      logic [7:0]  inject;
      logic [3:0]  restarts;
      logic [15:0] fmax;
      logic [15:0] fmin;
      logic [15:0] fref;
   } mss_cfg_type;

   localparam mss_cfg_type CFG_RST = '{
      method: 1'b0, atStart: 1'b0, coastStop: 1'b0, rideThru: 2'h0, bbNc: 1'b0,
      ctrlMode: CTRL_VF, thr: THR_VF, thrSet: 1'b0, delay: DELAY_RST,
      minBb: MINBB_RST, decel: DECEL_RST, vrec: VREC_RST, inject: INJECT_RST,
      restarts: 4'h0, fmax: FMAX_RST, fmin: FMIN_RST, fref: 16'h0000};
endpackage : mss_pkg
`default_nettype wire
